/* File: hw/rsv_device.sv */
// Notes on behaviour
// - Status bits seven to five read zero
// - Bit four: output within reference window
// - Bit three: overcurrent hiccup active
// - Bit two: die above early warning
// - Bit one: thermal shutdown active
// - Bit zero: output above power-good level
// - Reference starts 0.6V; programmable once enabled
// - Loop-select one: divider loop; zero: direct
// - Direct loop regulates to reference exactly
// - Host opens write gate before reference
// - Loop-select and code in one write
// - Small step keeps gate; host clears it
// - Host repeats gate then reference each time
// - Device clears gate after large change
// - Code linear 0.6V-1.87V, 10mV, resets zero
`include "rsv_cfg.svh"

module rsv_device (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,

    // Register link
    rsv_link_if.device       link,

    // Converter enable, acts as a reset of the register file
    input  wire logic        conv_enable,

    // Live analog comparator results
    input  wire logic        scaling_done_flag,
    input  wire logic        overcurrent_hiccup_flag,
    input  wire logic        thermal_early_warning_flag,
    input  wire logic        thermal_shutdown_flag,
    input  wire logic        power_good_in,

    // Scaling finished from the slew ramp, one-cycle pulse
    input  wire logic        ramp_finished,

    // Control outputs towards the analog core
    output logic [6:0]       ref_code,
    output logic             divider_loop,
    output logic             sense_feedback_node,
    output logic             sense_regulated_output,
    output logic             write_gate,
    output logic [7:0]       sys_ctrl
);

    // Write decode and gate handling
    logic       off;
    logic       wr_ref;
    logic       wr_sys;
    logic       gate_reopen;
    logic       pending;
    // Incoming reference word and its distance from the present code
    logic [6:0] new_code;
    logic       new_loop;
    logic [6:0] step;
    logic       small_step;
    // Control register reset word
    logic [7:0] sys_reset_word;
    // Status and read-back words
    logic [4:0] live_flags;
    logic [7:0] flags;
    logic [7:0] ref_word;
    logic [7:0] ident_word;
    logic [7:0] next_rdata;

    // Converter enable low clears the register file like a reset
    assign off = sys_rst || !conv_enable;

    // The gate must be open when the reference write lands
    assign wr_ref = link.wr_en && link.addr == `RSV_REG_REF && write_gate;
    // Writes to the identity and status offsets fall through unused
    assign wr_sys = link.wr_en && link.addr == `RSV_REG_SYS;

    // A host write that opens the gate starts a fresh command
    assign gate_reopen = wr_sys && link.wdata[`RSV_SYS_GATE_BIT];

    assign new_code = link.wdata[6:0];
    assign new_loop = link.wdata[`RSV_REF_LOOP_BIT];

    // Distance is taken against the code before the write lands
    always_comb begin
        if (new_code >= ref_code) begin
            step = new_code - ref_code;
        end else begin
            step = ref_code - new_code;
        end
    end

    // Five codes of 10 mV each make the 50 mV limit
    assign small_step = step <= 7'(`RSV_SMALL_STEP);

    // Reference code, resets to the 0.6V code
    always_ff @(posedge mclk) begin
        if (off) begin
            ref_code <= `RSV_REF_CODE_RST;
        end else if (wr_ref) begin
            ref_code <= new_code;
        end
    end

    // Loop select shares the write with the code
    always_ff @(posedge mclk) begin
        if (off) begin
            divider_loop <= `RSV_REF_LOOP_RST;
        end else if (wr_ref) begin
            divider_loop <= new_loop;
        end
    end

    // Direct sensing uses the reference unscaled
    assign sense_feedback_node    = divider_loop;
    assign sense_regulated_output = !divider_loop;

    // A large change auto-closes the gate once the ramp ends. Reopening the
    // gate drops an old pending clear, so a late ramp end of the previous
    // move cannot shut the gate ahead of the next reference write.
    always_ff @(posedge mclk) begin
        if (off) begin
            pending <= 1'b0;
        end else if (wr_ref) begin
            pending <= !small_step;
        end else if (gate_reopen || ramp_finished) begin
            pending <= 1'b0;
        end
    end

    assign sys_reset_word = `RSV_SYS_RST;

    // Control register, one flop per bit; only the gate bit clears itself
    for (genvar si = 0; si < 8; si++) begin : g_sys
        if (si == `RSV_SYS_GATE_BIT) begin : g_gate
            // Host write wins over the auto clear, so a reopened gate is not lost
            always_ff @(posedge mclk) begin
                if (off) begin
                    sys_ctrl[si] <= sys_reset_word[si];
                end else if (wr_sys) begin
                    sys_ctrl[si] <= link.wdata[si];
                end else if (pending && ramp_finished) begin
                    sys_ctrl[si] <= 1'b0;
                end
            end
        end else begin : g_plain
            always_ff @(posedge mclk) begin
                if (off) begin
                    sys_ctrl[si] <= sys_reset_word[si];
                end else if (wr_sys) begin
                    sys_ctrl[si] <= link.wdata[si];
                end
            end
        end
    end
    assign write_gate = sys_ctrl[`RSV_SYS_GATE_BIT];

    // Live comparator results in status bit order
    assign live_flags[`RSV_FLG_DONE]  = scaling_done_flag;
    assign live_flags[`RSV_FLG_OC]    = overcurrent_hiccup_flag;
    assign live_flags[`RSV_FLG_THERMAL_EARLY_WARNING_FLAG]  = thermal_early_warning_flag;
    assign live_flags[`RSV_FLG_OT]    = thermal_shutdown_flag;
    assign live_flags[`RSV_FLG_PGOOD] = power_good_in;

    // Reserved bits are tied low; the rest pass straight through, never held
    for (genvar fi = 0; fi < 8; fi++) begin : g_flag
        if (fi <= `RSV_FLG_DONE) begin : g_live
            assign flags[fi] = live_flags[fi];
        end else begin : g_resv
            assign flags[fi] = 1'b0;
        end
    end

    assign ref_word   = {divider_loop, ref_code};
    // Identity word is fixed; its value is arbitrary
    assign ident_word = {`RSV_VENDOR_CODE, `RSV_REVISION_CODE};

    // Unmapped offsets read as zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (link.addr)
            `RSV_REG_REF:   next_rdata = ref_word;
            `RSV_REG_SYS:   next_rdata = sys_ctrl;
            `RSV_REG_IDENT: next_rdata = ident_word;
            `RSV_REG_FLAGS: next_rdata = flags;
            default:        next_rdata = 8'h00;
        endcase
    end

    // Read data holds until the next read; flags are taken at the request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link.rdata <= 8'h00;
        end else if (link.rd_en) begin
            link.rdata <= next_rdata;
        end
    end

    // Answer strobe one cycle after the request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link.rvalid <= 1'b0;
        end else begin
            link.rvalid <= link.rd_en;
        end
    end

endmodule

/* File: hw/rsv_cfg.svh */
`ifndef RSV_CFG_SVH
`define RSV_CFG_SVH

// Register offsets on the two-wire port
`define RSV_REG_REF        8'h00
`define RSV_REG_SYS        8'h01
`define RSV_REG_IDENT      8'h02
`define RSV_REG_FLAGS      8'h03

// Reference register fields
`define RSV_REF_LOOP_BIT   7
`define RSV_REF_CODE_RST   7'h00
`define RSV_REF_LOOP_RST   1'b1

// System control register fields and reset value
`define RSV_SYS_GATE_BIT   6
`define RSV_SYS_RST        8'ha1

// Identity fields; values are arbitrary
`define RSV_VENDOR_CODE    4'h5
`define RSV_REVISION_CODE  4'h1

// Flag positions in the status register
`define RSV_FLG_DONE       4
`define RSV_FLG_OC         3
`define RSV_FLG_THERMAL_EARLY_WARNING_FLAG       2
`define RSV_FLG_OT         1
`define RSV_FLG_PGOOD      0

// Reference step is 10 mV, so 50 mV is five codes
`define RSV_SMALL_STEP_MV  50
`define RSV_STEP_MV        10
`define RSV_SMALL_STEP     (`RSV_SMALL_STEP_MV / `RSV_STEP_MV)

`endif

/* File: hw/rsv_pkg.sv */
package rsv_pkg;
    typedef enum logic [1:0] {
        RSV_HOST_IDLE,
        RSV_HOST_GATE,
        RSV_HOST_REF,
        RSV_HOST_CLOSE
    } rsv_host_state_t;
endpackage

/* File: hw/rsv_link_if.sv */
interface rsv_link_if;
    // One register access per cycle when wr_en or rd_en is high
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;

    modport device (
        input  wr_en,
        input  rd_en,
        input  addr,
        input  wdata,
        output rdata,
        output rvalid
    );

    modport host (
        output wr_en,
        output rd_en,
        output addr,
        output wdata,
        input  rdata,
        input  rvalid
    );
endinterface

/* File: hw/rsv_host.sv */
`include "rsv_cfg.svh"

module rsv_host (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Register link
    rsv_link_if.host         link,
    // User request: one scaling step per pulse
    input  wire logic        go,
    input  wire logic        loop_divider,
    input  wire logic [6:0]  target_code,
    input  wire logic [7:0]  sys_base,
    output logic             busy,
    // User register read
    input  wire logic        rd_req,
    input  wire logic [7:0]  rd_addr,
    output logic [7:0]       rd_data,
    output logic             rd_done
);

    rsv_pkg::rsv_host_state_t state;
    logic [7:0] tgt;
    logic [7:0] base;
    logic       issue_rd;

    assign busy     = state != rsv_pkg::RSV_HOST_IDLE;
    assign issue_rd = rd_req && !busy && !go;

    // Each step reopens the gate, writes reference, then closes the gate
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= rsv_pkg::RSV_HOST_IDLE;
            tgt   <= 8'h00;
            base  <= 8'h00;
        end else begin
            unique case (state)
                rsv_pkg::RSV_HOST_IDLE: if (go) begin
                    tgt   <= {loop_divider, target_code};
                    base  <= sys_base;
                    state <= rsv_pkg::RSV_HOST_GATE;
                end
                rsv_pkg::RSV_HOST_GATE:  state <= rsv_pkg::RSV_HOST_REF;
                rsv_pkg::RSV_HOST_REF:   state <= rsv_pkg::RSV_HOST_CLOSE;
                rsv_pkg::RSV_HOST_CLOSE: state <= rsv_pkg::RSV_HOST_IDLE;
            endcase
        end
    end

    always_comb begin
        link.wr_en = 1'b0;
        link.rd_en = issue_rd;
        link.addr  = rd_addr;
        link.wdata = 8'h00;
        unique case (state)
            rsv_pkg::RSV_HOST_GATE: begin
                link.wr_en = 1'b1;
                link.rd_en = 1'b0;
                link.addr  = `RSV_REG_SYS;
                link.wdata = base | (8'h01 << `RSV_SYS_GATE_BIT);
            end
            rsv_pkg::RSV_HOST_REF: begin
                link.wr_en = 1'b1;
                link.rd_en = 1'b0;
                link.addr  = `RSV_REG_REF;
                link.wdata = tgt;
            end
            rsv_pkg::RSV_HOST_CLOSE: begin
                // Closing is harmless after a large step the device closed itself
                link.wr_en = 1'b1;
                link.rd_en = 1'b0;
                link.addr  = `RSV_REG_SYS;
                link.wdata = base & ~(8'h01 << `RSV_SYS_GATE_BIT);
            end
            rsv_pkg::RSV_HOST_IDLE: ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
            rd_done <= 1'b0;
        end else begin
            rd_done <= link.rvalid;
            if (link.rvalid) begin
                rd_data <= link.rdata;
            end
        end
    end

endmodule

/* File: bench/rsv_link_assertions.sv */
module rsv_link_assertions (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // Link signals
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence s_open; wr_en && addr == 8'h01 && wdata[6]; endsequence
    sequence s_ref; wr_en && addr == 8'h00; endsequence
    sequence s_close; wr_en && addr == 8'h01 && !wdata[6]; endsequence
    property p_rvalid; rd_en |=> rvalid; endproperty
    property p_no_stray; !rd_en |=> !rvalid; endproperty
    property p_resv; rd_en && addr == 8'h03 |=> rdata[7:5] == 3'h0; endproperty
    property p_ident; rd_en && addr == 8'h02 |=> rdata == 8'h51; endproperty
    property p_unmapped; rd_en && addr > 8'h03 |=> rdata == 8'h00; endproperty
    property p_gate_first; s_open |=> s_ref; endproperty
    property p_close; s_ref |=> s_close; endproperty
    property p_step; s_open ##1 s_ref ##1 s_close |=> !wr_en; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_no_stray: assert property (p_no_stray) else $error("stray read answer");
    a_resv: assert property (p_resv) else $error("reserved flags set");
    a_ident: assert property (p_ident) else $error("identity wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_gate_first: assert property (p_gate_first) else $error("no ref after gate");
    a_close: assert property (p_close) else $error("gate not closed");
    a_step: assert property (p_step) else $error("step too long");
endmodule

/* File: bench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0, sys_rst = 1'b1, conv_enable = 1'b1, ramp_finished = 1'b0;
    logic [4:0] flg = 5'h00;
    logic       go = 1'b0, loop_divider = 1'b0, busy, rd_req = 1'b0, rd_done;
    logic [6:0] target_code = 7'h00, ref_code;
    logic [7:0] sys_base = 8'h00, rd_addr = 8'h00, rd_data, sys_ctrl;
    logic       divider_loop, sense_feedback_node, sense_regulated_output, write_gate;
    int         miscompares = 0, n_compared = 0, cyc = 0;
    logic [31:0] rs = 32'h0000_7136; // Seed 28982
    rsv_link_if link ();
    rsv_device u_rsv_device (.mclk(mclk), .sys_rst(sys_rst), .link(link),
        .conv_enable(conv_enable), .scaling_done_flag(flg[4]),
        .overcurrent_hiccup_flag(flg[3]), .thermal_early_warning_flag(flg[2]),
        .thermal_shutdown_flag(flg[1]), .power_good_in(flg[0]),
        .ramp_finished(ramp_finished), .ref_code(ref_code), .divider_loop(divider_loop),
        .sense_feedback_node(sense_feedback_node),
        .sense_regulated_output(sense_regulated_output), .write_gate(write_gate),
        .sys_ctrl(sys_ctrl));
    rsv_host u_rsv_host (.mclk(mclk), .sys_rst(sys_rst), .link(link), .go(go),
        .loop_divider(loop_divider), .target_code(target_code), .sys_base(sys_base),
        .busy(busy), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_done(rd_done));
    rsv_link_assertions u_rsv_link_assertions (.mclk(mclk), .sys_rst(sys_rst),
        .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata),
        .rdata(link.rdata), .rvalid(link.rvalid));
    always #12.5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // Reserved bits stay clear whatever the flags do
    function automatic logic [7:0] flags_exp(input logic [4:0] f);
        return {3'h0, f};
    endfunction
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #2;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_req = 1'b1;
        rd_addr = a;
        tick();
        rd_req = 1'b0;
        for (int i = 0; i < 8 && rd_done !== 1'b1; i++) tick();
        d = rd_data;
        tick();
    endtask
    task automatic step(input logic lp, input logic [6:0] c, input logic [7:0] b);
        go = 1'b1;
        loop_divider = lp;
        target_code = c;
        sys_base = b;
        ramp_finished = rs[9];
        tick();
        go = 1'b0;
        ramp_finished = 1'b0;
        for (int i = 0; i < 8 && busy !== 1'b0; i++) tick();
        tick();
        chk("ref_code", {1'b0, ref_code}, {1'b0, c});
        chk("loop", {5'h00, divider_loop, sense_feedback_node, sense_regulated_output},
            {5'h00, lp, lp, !lp});
        chk("sys_ctrl", sys_ctrl, b & 8'hbf);
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        logic [7:0] d;
        repeat (16) tick();
        sys_rst = 0;
        tick();
        chk("rst ref", {divider_loop, ref_code}, 8'h80);
        step(1'b0, 7'h7f, 8'ha1); // Full-scale code, direct loop
        step(1'b1, 7'h7c, 8'ha1); // Three-code move keeps the gate
        conv_enable = 1'b0;
        tick();
        conv_enable = 1'b1;
        tick();
        chk("en ref", {divider_loop, ref_code}, 8'h80);
        rd(8'h02, d);
        chk("ident", d, 8'h51);
        rd(8'h07, d);
        chk("unmapped", d, 8'h00);
        for (int k = 0; k < 60; k++) begin
            rs = xs(rs);
            flg = rs[4:0];
            step(rs[7], rs[14:8], rs[23:16]);
            rd(8'h03, d);
            chk("flags", d, flags_exp(flg));
            rd(8'h03, d);
            chk("flags again", d, flags_exp(flg));
        end
        finish_test();
    end
endmodule
